// [design/caas_alert_bank.sv]
// Alert status bank for cell, auxiliary and balance-switch comparisons
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Cell alert bit 13 is the OR of aux1 cold and hot flags.
// - Cell alert bit 12 is the OR of aux0 cold and hot flags.
// - Each cell summary bit is OR of its overvoltage and undervoltage flags.
// - Aux cold flag set when aux voltage exceeds cold threshold.
// - Aux hot flag, in undervoltage register, set when voltage below hot threshold.
// - Cell overvoltage flag set only when enabled and above threshold.
// - Cell undervoltage flag set only when enabled and below threshold.
// - Twelve balance diagnostic flags compare against threshold picked by 3-bit select.
// - Flags follow each acquisition; not sticky, writes cannot clear.
// - Balance summary output is OR of all balance diagnostic flags.
// - Cold summary output is OR of both aux cold flags.
//
// The address-and-strobe port was left to the implementer.
module caas_alert_bank
	import caas_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic acq_done_i,
	input wire logic [NUM_CELLS*CODE_W-1:0] cell_codes_i,
	input wire logic [2*CODE_W-1:0] aux_codes_i,
	input wire logic [NUM_BALSW*CODE_W-1:0] balsw_codes_i,
	input wire logic [CODE_W-1:0] overvoltage_threshold_i,
	input wire logic [CODE_W-1:0] undervoltage_threshold_i,
	input wire logic [CODE_W-1:0] aux_cold_threshold_i,
	input wire logic [CODE_W-1:0] aux_hot_threshold_i,
	input wire logic [NUM_CELLS-1:0] cell_overvoltage_enable_i,
	input wire logic [NUM_CELLS-1:0] cell_undervoltage_enable_i,
	input wire logic [SEL_W-1:0] balance_diag_select_i,
	input wire logic [(1<<SEL_W)*CODE_W-1:0] balance_diag_thresholds_i,
	output logic balance_switch_summary_o,
	output logic any_aux_cold_summary_o
);
	////////////////////////////////////////////////////////////////////////////////
	wire logic [NUM_CELLS-1:0] cell_overvoltage_flags;
	wire logic [NUM_CELLS-1:0] cell_undervoltage_flags;
	wire logic [NUM_BALSW-1:0] balance_switch_diag_flags;
	wire logic [1:0] aux_cold_flag;
	wire logic [1:0] aux_hot_flag;
	wire logic [CODE_W-1:0] balsw_threshold;
	wire logic [NUM_CELLS-1:0] cell_alert_summary_bits;
	wire logic aux0_alert_summary;
	wire logic aux1_alert_summary;
	wire logic [DATA_W-1:0] reg_summary;
	wire logic [DATA_W-1:0] reg_ov;
	wire logic [DATA_W-1:0] reg_uv;
	wire logic [DATA_W-1:0] reg_balsw;
	wire logic [DATA_W-1:0] next_rdata;

	// Threshold picked by select; the tap table comes from the threshold block
	assign balsw_threshold = balance_diag_thresholds_i[balance_diag_select_i*CODE_W +: CODE_W];

	////////////////////////////////////////////////////////////////////////////////
	// Comparators update only on acquisition done, so flags track the last result
	for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell
		caas_cmp u_ov (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.acq_done_i(acq_done_i),
			.enable_i(cell_overvoltage_enable_i[n]),
			.value_i(cell_codes_i[n*CODE_W +: CODE_W]),
			.threshold_i(overvoltage_threshold_i),
			.above_i(1'b1),
			.flag_o(cell_overvoltage_flags[n])
		);
		caas_cmp u_uv (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.acq_done_i(acq_done_i),
			.enable_i(cell_undervoltage_enable_i[n]),
			.value_i(cell_codes_i[n*CODE_W +: CODE_W]),
			.threshold_i(undervoltage_threshold_i),
			.above_i(1'b0),
			.flag_o(cell_undervoltage_flags[n])
		);
	end

	for (genvar a = 0; a < 2; a++) begin : g_aux
		caas_cmp u_cold (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.acq_done_i(acq_done_i),
			.enable_i(1'b1),
			.value_i(aux_codes_i[a*CODE_W +: CODE_W]),
			.threshold_i(aux_cold_threshold_i),
			.above_i(1'b1),
			.flag_o(aux_cold_flag[a])
		);
		caas_cmp u_hot (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.acq_done_i(acq_done_i),
			.enable_i(1'b1),
			.value_i(aux_codes_i[a*CODE_W +: CODE_W]),
			.threshold_i(aux_hot_threshold_i),
			.above_i(1'b0),
			.flag_o(aux_hot_flag[a])
		);
	end

	for (genvar b = 0; b < NUM_BALSW; b++) begin : g_balsw
		caas_cmp u_bal (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.acq_done_i(acq_done_i),
			.enable_i(1'b1),
			.value_i(balsw_codes_i[b*CODE_W +: CODE_W]),
			.threshold_i(balsw_threshold),
			.above_i(1'b1),
			.flag_o(balance_switch_diag_flags[b])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Summaries are combinational so they never lag the flags
	assign cell_alert_summary_bits = cell_overvoltage_flags | cell_undervoltage_flags;
	assign aux0_alert_summary = aux_cold_flag[0] | aux_hot_flag[0];
	assign aux1_alert_summary = aux_cold_flag[1] | aux_hot_flag[1];
	assign balance_switch_summary_o = |balance_switch_diag_flags;
	assign any_aux_cold_summary_o = |aux_cold_flag;

	// Register images; unassigned bits stay zero
	assign reg_summary = {2'h0, aux1_alert_summary, aux0_alert_summary, cell_alert_summary_bits};
	assign reg_ov = {2'h0, aux_cold_flag[1], aux_cold_flag[0], cell_overvoltage_flags};
	assign reg_uv = {2'h0, aux_hot_flag[1], aux_hot_flag[0], cell_undervoltage_flags};
	assign reg_balsw = {4'h0, balance_switch_diag_flags};

	// Unmapped addresses read zero; writes have no target at all
	assign next_rdata = !reg_rd_i ? DATA_ZERO :
		(reg_addr_i == ADDR_CELL_ALERT_SUMMARY) ? reg_summary :
		(reg_addr_i == ADDR_CELL_OVERVOLTAGE_ALERTS) ? reg_ov :
		(reg_addr_i == ADDR_CELL_UNDERVOLTAGE_ALERTS) ? reg_uv :
		(reg_addr_i == ADDR_BALANCE_SWITCH_ALERTS) ? reg_balsw : DATA_ZERO;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= DATA_ZERO;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end
endmodule // caas_alert_bank

// [design/caas_cmp.sv]
// One comparison flag that is re-evaluated at every acquisition
module caas_cmp
	import caas_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic acq_done_i,
	input wire logic enable_i,
	input wire logic [CODE_W-1:0] value_i,
	input wire logic [CODE_W-1:0] threshold_i,
	input wire logic above_i,
	output logic flag_o
);
	wire logic next_flag;
	assign next_flag = enable_i && (above_i ? (value_i > threshold_i) : (value_i < threshold_i));

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			flag_o <= 1'b0;
		end else if (acq_done_i) begin
			flag_o <= next_flag;
		end
	end
endmodule // caas_cmp

// [design/caas_pkg.sv]
// Package of register map, field layout and widths for the cell and aux alert status bank
package caas_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_CELLS = 12;
	localparam int unsigned NUM_BALSW = 12;
	localparam int unsigned SEL_W = 3;
	localparam int unsigned CODE_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CELL_ALERT_SUMMARY = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CELL_OVERVOLTAGE_ALERTS = 8'h05;
	localparam logic [ADDR_W-1:0] ADDR_CELL_UNDERVOLTAGE_ALERTS = 8'h07;
	localparam logic [ADDR_W-1:0] ADDR_BALANCE_SWITCH_ALERTS = 8'h08;
	localparam int unsigned BIT_AUX0 = 12;
	localparam int unsigned BIT_AUX1 = 13;
	localparam int unsigned BIT_CELL_LO = 0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [1:0] AUX_ZERO = 2'h0;
	localparam logic [NUM_CELLS-1:0] CELL_ZERO = 12'h000;
	localparam logic [NUM_BALSW-1:0] BALSW_ZERO = 12'h000;
endpackage : caas_pkg

// [test/caas_alert_bank_bench.sv]
// Self-checking bench for the alert status bank
module caas_alert_bank_bench
	import caas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, acq = 1'b0, bsum, csum;
	logic [7:0] addr = 8'h00;
	logic [15:0] rdata;
	logic [143:0] cc = {12{12'h500}}, bc = {12{12'h100}};
	logic [23:0] ac = {2{12'h500}};
	logic [95:0] bt = {8{12'hFFF}};
	logic [11:0] oen = 12'hFFF;
	logic [11:0] uen = 12'hFFF;
	logic [2:0] sel = 3'h0;
	int num_errors = 0, checks = 0;
	caas_alert_bank caas_alert_bank_inst (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
		.reg_wdata_i({16{wr}}), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.acq_done_i(acq), .cell_codes_i(cc), .aux_codes_i(ac), .balsw_codes_i(bc),
		.overvoltage_threshold_i(12'h800), .undervoltage_threshold_i(12'h200),
		.aux_cold_threshold_i(12'h800), .aux_hot_threshold_i(12'h200),
		.cell_overvoltage_enable_i(oen), .cell_undervoltage_enable_i(uen),
		.balance_diag_select_i(sel), .balance_diag_thresholds_i(bt),
		.balance_switch_summary_o(bsum), .any_aux_cold_summary_o(csum));
	////////////////////////////////////////////////////////////////////////////
	initial forever #4 clk = ~clk;
	task automatic chk(input string n, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	// Reads every mapped place and two unmapped ones, all expected clear
	task automatic t_zero();
		logic [7:0] al[6] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h06, 8'h09};
		foreach (al[i]) rd_chk(al[i], 16'h0000);
		chk("sums", {14'h0000, bsum, csum}, 16'h0000);
	endtask
	// Cell 2 overvoltage and cell 1 undervoltage are disabled, cell 3 sits on the threshold
	task automatic t_fire();
		@(posedge clk);
		cc <= {12'h100, {7{12'h500}}, 12'h800, 12'h900, 12'h100, 12'h900};
		ac <= {12'h100, 12'h900};
		bc <= {12'h600, {7{12'h100}}, 12'h500, 12'h100, 12'h100, 12'h600};
		bt[71:60] <= 12'h500;
		sel <= 3'h5;
		oen <= 12'hFFB;
		uen <= 12'hFFD;
		acq <= 1'b1;
		@(posedge clk);
		acq <= 1'b0;
		rd_chk(8'h04, 16'h3801);
		rd_chk(8'h05, 16'h1001);
		rd_chk(8'h07, 16'h2800);
		rd_chk(8'h08, 16'h0801);
		chk("sums", {14'h0000, bsum, csum}, 16'h0003);
		@(posedge clk);
		wr <= 1'b1;
		addr <= 8'h05;
		@(posedge clk);
		wr <= 1'b0;
		rd_chk(8'h05, 16'h1001);
	endtask
	// Mid-run reset must drop every flag that the last acquisition raised
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk("sums", {14'h0000, bsum, csum}, 16'h0000);
		rd_chk(8'h05, 16'h0000);
		rd_chk(8'h07, 16'h0000);
	endtask
	task automatic t_clear();
		@(posedge clk);
		cc <= {12{12'h500}};
		ac <= {2{12'h500}};
		bc <= {12{12'h100}};
		acq <= 1'b1;
		@(posedge clk);
		acq <= 1'b0;
		t_zero();
	endtask
	task automatic summarize();
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_zero();
		t_fire();
		t_reset();
		t_fire();
		t_clear();
		summarize();
	end
	// The tests need under a hundred cycles, so this leaves ample margin
	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule // caas_alert_bank_bench

// [test/caas_alert_bank_chk.sv]
// Checker for read timing, reserved bits and summaries of the alert bank
module caas_chk
	import caas_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic acq_done_i,
	input wire logic [2*CODE_W-1:0] aux_codes_i,
	input wire logic [CODE_W-1:0] aux_cold_threshold_i,
	input wire logic balance_switch_summary_o,
	input wire logic any_aux_cold_summary_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic cold;
	assign cold = (aux_codes_i[11:0] > aux_cold_threshold_i) |
		(aux_codes_i[23:12] > aux_cold_threshold_i);
	// Reads beside an acquisition are skipped: they return the image from before it while the summaries already move
	sequence rd_q(logic [7:0] a);
		reg_rd_i && reg_addr_i == a && !acq_done_i;
	endsequence
	idle_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data without read");
	resv_alert_a: assert property (reg_rd_i && reg_addr_i < 8'h08 |=> !reg_rdata_o[15:14])
		else $error("reserved alert bits set");
	resv_bal_a: assert property (reg_rd_i && reg_addr_i == 8'h08 |=> !reg_rdata_o[15:12])
		else $error("reserved balance bits set");
	cold_hold_a: assert property (!acq_done_i |=> $stable(any_aux_cold_summary_o))
		else $error("cold summary moved");
	bal_hold_a: assert property (!acq_done_i |=> $stable(balance_switch_summary_o))
		else $error("balance summary moved");
	cold_sum_a: assert property (acq_done_i |=> any_aux_cold_summary_o == $past(cold))
		else $error("cold summary wrong");
	cold_reg_a: assert property (rd_q(8'h05) |=> |reg_rdata_o[13:12] == any_aux_cold_summary_o)
		else $error("cold bits disagree");
	bal_reg_a: assert property (rd_q(8'h08) |=> |reg_rdata_o[11:0] == balance_switch_summary_o)
		else $error("balance bits disagree");
endmodule // caas_chk
////////////////////////////////////////////////////////////////////////////////
bind caas_alert_bank caas_chk caas_chk_inst (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .acq_done_i, .aux_codes_i, .aux_cold_threshold_i, .balance_switch_summary_o,
	.any_aux_cold_summary_o);
